// *** phy_mgmt_pkg.sv ***
/*
 * Constants for the vendor management register bank of a 10/100 PHY.
 * Assumes a single 200 MHz reference clock and an MDIO style serial port.
 */
// Functional notes
// R1: Register indices eight to fifteen are reserved and read as zero.
// R2: Status control bit 13 enables carrier sense disconnect, resets zero.
// R3: Status control bit 12 enables transmit flow control, resets zero.
// R4: Status control bit 11 shows receive deserializer in sync, read only.
// R5: Bits 10 and 9 show 100 and 10 Mbps power down, reset one.
// R6: Bit 8 shows 10 Mbps receive polarity, one means reversed.
// R7: Bit 1 shows speed 100, bit 0 shows full duplex.
// R8: Special bits 15 and 14 bypass scrambler and 4B5B coding, reset zero.
// R9: Special bits 13 and 12 force H and 34 test patterns.
// R10: Special bit 11 forces 100 Mbps link good, resets zero.
// R11: Special bit 9 disables transmit carrier sense, resets zero.
// R12: Special bit 8 disables dynamic power down, resets zero.
// R13: Special bit 7 puts auto-negotiation into loopback, resets zero.
// R14: Special bit 6 tri-states the line transmit drivers, resets zero.
// R15: Bit 5 bypasses receive filter, bit 4 disables auto polarity.
// R16: Bit 3 disables squelch test, bit 2 enables extended squelch.
// R17: Bit 1 disables link integrity, bit 0 disables jabber.
// R18: Address register reads fixed address 00001b, writes ignored.
// R19: False carrier count is sixteen bits, cleared when read.
// R20: Disconnect counter saturates at maximum and clears on read.
// R21: Error frame counter counts at most once per errored frame.
// R22: Symbol error counter adds one per six consecutive bad symbols.
// R23: A read racing an event returns old value, keeps the event.
`default_nettype none
package phy_mgmt_pkg;
    // ------------------------------------------------------------
    // Register indices.
    // ------------------------------------------------------------
    localparam logic [4:0] REG_RSVD_LO = 5'h08;
    localparam logic [4:0] REG_RSVD_HI = 5'h0F;
    localparam logic [4:0] REG_STATUS_CTRL = 5'h10;
    localparam logic [4:0] REG_SPECIAL_CTRL = 5'h11;
    localparam logic [4:0] REG_MGMT_ADDR = 5'h12;
    localparam logic [4:0] REG_FALSE_CARRIER = 5'h13;
    localparam logic [4:0] REG_DISCONNECT = 5'h14;
    localparam logic [4:0] REG_ERROR_FRAME = 5'h15;
    localparam logic [4:0] REG_SYMBOL_ERROR = 5'h16;
    // ------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------
    localparam int SC_CSD_BIT = 13;
    localparam int SC_TXFC_BIT = 12;
    localparam int SC_WR_HI = 15;
    localparam int SC_WR_LO = 12;
    localparam logic [3:0] SC_WR_RESET = 4'h0;
    localparam logic [15:0] SPECIAL_RESET = 16'h0000;
    localparam logic [4:0] PHY_ADDRESS = 5'h01;
    localparam logic PD_RESET = 1'b1;
    localparam int SYMBOL_RUN_LEN = 6;
    // ------------------------------------------------------------
    // Serial frame constants.
    // ------------------------------------------------------------
    localparam int MDIO_PREAMBLE = 32;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;
    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_START = 3'b001,
        SER_OP = 3'b011,
        SER_PHY = 3'b010,
        SER_REG = 3'b110,
        SER_TURN = 3'b111,
        SER_DATA = 3'b101
    } ser_state_e;
endpackage
`default_nettype wire

// *** sat_clr_counter.sv ***
/*
 * Saturating event counter with clear on read.
 * Assumes incr and clr come from logic on the same clock.
 */
`default_nettype none
module sat_clr_counter #(
    parameter int WIDTH = 16
) (
    input wire logic refClk,
    input wire logic rstN,
    input wire logic ce,
    input wire logic incr,
    input wire logic clr,
    output logic [WIDTH-1:0] count
);
    localparam logic [WIDTH-1:0] CNT_MAX = '1;
    logic [WIDTH-1:0] base;
    logic [WIDTH-1:0] next_count;

    // ------------------------------------------------------------
    // Next value.
    // ------------------------------------------------------------
    // R23: clear keeps event.
    always_comb begin
        base = clr ? '0 : count;
        next_count = base;
        if (incr && base != CNT_MAX) begin
            next_count = base + 1'b1;
        end
    end

    // R20: freeze when full.
    always_ff @(posedge refClk or negedge rstN) begin
        if (!rstN) begin
            count <= '0;
        end else if (ce) begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    chk_count_saturate: assert property (@(posedge refClk) disable iff (!rstN) // R20
        (count == CNT_MAX && !clr) |=> count == CNT_MAX)
        else $error("Counter left its full value without a read.");
    chk_clear_keeps_event: assert property (@(posedge refClk) disable iff (!rstN) // R23
        (ce && clr && incr) |=> count == 1)
        else $error("Event lost while clearing on read.");
    cov_count_full: cover property (@(posedge refClk) disable iff (!rstN)
        count == CNT_MAX);
endmodule
`default_nettype wire

// *** phy_vendor_mgmt_registers.sv ***
/*
 * Vendor management registers 16 to 22 of a 10/100 PHY, reached over
 * the serial management port (clock and bidirectional data pins).
 * Assumes status and event inputs come from PHY logic on refClk, while
 * the management clock and data pins are asynchronous.
 */
`default_nettype none
module phy_vendor_mgmt_registers
    import phy_mgmt_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic deserInSync,
    input wire logic powerDown100,
    input wire logic powerDown10,
    input wire logic polarityReversed,
    input wire logic speed100,
    input wire logic fullDuplex,
    input wire logic falseCarrierEvt,
    input wire logic disconnectEvt,
    input wire logic rxFrameActive,
    input wire logic rxErrorEvt,
    input wire logic symbolValid,
    input wire logic symbolBad,
    output logic carrierDisconnectEn,
    output logic txFlowCtrlEn,
    output logic scramblerBypass,
    output logic encoderBypass,
    output logic forceHPattern,
    output logic force34Pattern,
    output logic forceLinkGood,
    output logic txCarrierSenseDis,
    output logic dynPowerDownDis,
    output logic anegLoopback,
    output logic txDriverTristate,
    output logic rxFilterBypass,
    output logic autoPolarityDis,
    output logic squelchTestDis,
    output logic extSquelchEn,
    output logic linkIntegrityDis,
    output logic jabberDis
);
    import phy_mgmt_pkg::*;

    // ------------------------------------------------------------
    // Reset release and pin synchronisers.
    // ------------------------------------------------------------
    logic rstMeta, rstN;
    logic mdcMeta, mdcSync, mdcPrev;
    logic mdioMeta, mdioSync;
    logic mdcRise, mdcFall;

    // Reset is released through two flops.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // Management pins pass two flops before use.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            mdcMeta <= 1'b0;
            mdcSync <= 1'b0;
            mdcPrev <= 1'b0;
            mdioMeta <= 1'b1;
            mdioSync <= 1'b1;
        end else if (ce) begin
            mdcMeta <= mdc;
            mdcSync <= mdcMeta;
            mdcPrev <= mdcSync;
            mdioMeta <= mdioIn;
            mdioSync <= mdioMeta;
        end
    end

    assign mdcRise = ce && mdcSync && !mdcPrev;
    assign mdcFall = ce && !mdcSync && mdcPrev;

    // ------------------------------------------------------------
    // Serial frame decoder.
    // ------------------------------------------------------------
    ser_state_e state;
    logic [5:0] preCnt;
    logic [3:0] bitCnt;
    logic [1:0] opCode;
    logic [4:0] phyAddr;
    logic [4:0] regAddr;
    logic [15:0] wrShift;
    logic [15:0] rdShift;
    logic [15:0] rdValue;
    logic addrMatch, isRead, regLast, dataLast;
    logic readPulse, writePulse;

    assign addrMatch = (phyAddr == PHY_ADDRESS);
    assign isRead = (opCode == OP_READ);
    assign regLast = mdcRise && state == SER_REG && bitCnt == 4'd4;
    assign dataLast = mdcRise && state == SER_DATA && bitCnt == 4'd15;
    // The last address or data bit enters its shift register on that same rise,
    // so the access strobes act one cycle later, once the whole field is in place.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            readPulse <= 1'b0;
            writePulse <= 1'b0;
        end else if (ce) begin
            readPulse <= regLast && isRead && addrMatch;
            writePulse <= dataLast && opCode == OP_WRITE && addrMatch;
        end
    end

    // Frame state follows the sampled data on each clock rise.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state <= SER_IDLE;
            preCnt <= '0;
            bitCnt <= '0;
        end else if (mdcRise) begin
            bitCnt <= bitCnt + 4'd1;
            case (state)
                SER_IDLE: begin
                    if (mdioSync) begin
                        if (preCnt != 6'(MDIO_PREAMBLE)) begin
                            preCnt <= preCnt + 6'd1;
                        end
                    end else begin
                        preCnt <= '0;
                        if (preCnt == 6'(MDIO_PREAMBLE)) begin
                            state <= SER_START;
                        end
                    end
                end
                SER_START: begin
                    bitCnt <= '0;
                    state <= mdioSync ? SER_OP : SER_IDLE;
                end
                SER_OP: begin
                    if (bitCnt == 4'd1) begin
                        bitCnt <= '0;
                        state <= SER_PHY;
                    end
                end
                SER_PHY: begin
                    if (bitCnt == 4'd4) begin
                        bitCnt <= '0;
                        state <= SER_REG;
                    end
                end
                SER_REG: begin
                    if (bitCnt == 4'd4) begin
                        bitCnt <= '0;
                        state <= SER_TURN;
                    end
                end
                SER_TURN: begin
                    if (bitCnt == 4'd1) begin
                        bitCnt <= '0;
                        state <= SER_DATA;
                    end
                end
                SER_DATA: begin
                    if (bitCnt == 4'd15) begin
                        bitCnt <= '0;
                        state <= SER_IDLE;
                    end
                end
                default: begin
                    state <= SER_IDLE;
                end
            endcase
        end
    end

    // Header and write data shift in on clock rises.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            opCode <= '0;
            phyAddr <= '0;
            regAddr <= '0;
            wrShift <= '0;
        end else if (mdcRise) begin
            case (state)
                SER_OP: opCode <= {opCode[0], mdioSync};
                SER_PHY: phyAddr <= {phyAddr[3:0], mdioSync};
                SER_REG: regAddr <= {regAddr[3:0], mdioSync};
                SER_DATA: wrShift <= {wrShift[14:0], mdioSync};
                default: begin
                end
            endcase
        end
    end

    // Read data is driven on falls: zero in turnaround, then MSB first.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            rdShift <= '0;
            mdioOut <= 1'b1;
            mdioOe <= 1'b0;
        end else if (ce && readPulse) begin
            rdShift <= rdValue;
        end else if (mdcFall) begin
            if (state == SER_TURN && bitCnt == 4'd1 && isRead && addrMatch) begin
                mdioOe <= 1'b1;
                mdioOut <= 1'b0;
            end else if (state == SER_DATA && mdioOe) begin
                mdioOut <= rdShift[15];
                rdShift <= {rdShift[14:0], 1'b0};
            end else begin
                mdioOe <= 1'b0;
                mdioOut <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Writable control registers.
    // ------------------------------------------------------------
    logic [3:0] statusCtrlWr;
    logic [15:0] specialCtrl;

    // R2 R3: status control writes.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            statusCtrlWr <= SC_WR_RESET;
        end else if (ce && writePulse && regAddr == REG_STATUS_CTRL) begin
            statusCtrlWr <= wrShift[SC_WR_HI:SC_WR_LO];
        end
    end

    // R8 R9 R10: special control writes.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            specialCtrl <= SPECIAL_RESET;
        end else if (ce && writePulse && regAddr == REG_SPECIAL_CTRL) begin
            specialCtrl <= wrShift;
        end
    end

    // R2 R3: status control outputs.
    assign carrierDisconnectEn = statusCtrlWr[SC_CSD_BIT-SC_WR_LO];
    assign txFlowCtrlEn = statusCtrlWr[SC_TXFC_BIT-SC_WR_LO];
    // R8 R9 R10: test and bypass outputs.
    assign scramblerBypass = specialCtrl[15];
    assign encoderBypass = specialCtrl[14];
    assign forceHPattern = specialCtrl[13];
    assign force34Pattern = specialCtrl[12];
    assign forceLinkGood = specialCtrl[11];
    // R11 R12 R13: carrier, power, negotiation.
    assign txCarrierSenseDis = specialCtrl[9];
    assign dynPowerDownDis = specialCtrl[8];
    assign anegLoopback = specialCtrl[7];
    // R14 R15 R16 R17: line and 10 Mbps controls.
    assign txDriverTristate = specialCtrl[6];
    assign rxFilterBypass = specialCtrl[5];
    assign autoPolarityDis = specialCtrl[4];
    assign squelchTestDis = specialCtrl[3];
    assign extSquelchEn = specialCtrl[2];
    assign linkIntegrityDis = specialCtrl[1];
    assign jabberDis = specialCtrl[0];

    // ------------------------------------------------------------
    // Status capture.
    // ------------------------------------------------------------
    logic inSync, pd100, pd10, polRev, spd100, fdx;

    // R4 R5 R6 R7: status flops, power down resets high.
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            inSync <= 1'b0;
            pd100 <= PD_RESET;
            pd10 <= PD_RESET;
            polRev <= 1'b0;
            spd100 <= 1'b0;
            fdx <= 1'b0;
        end else if (ce) begin
            inSync <= deserInSync;
            pd100 <= powerDown100;
            pd10 <= powerDown10;
            polRev <= polarityReversed;
            spd100 <= speed100;
            fdx <= fullDuplex;
        end
    end

    // ------------------------------------------------------------
    // Frame error qualifiers.
    // ------------------------------------------------------------
    logic errSeen;
    logic errFrameInc;
    logic [2:0] badRun;
    logic symbolInc;

    // R21: one count per errored frame.
    assign errFrameInc = rxFrameActive && rxErrorEvt && !errSeen;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            errSeen <= 1'b0;
        end else if (ce) begin
            errSeen <= rxFrameActive && (errSeen || rxErrorEvt);
        end
    end

    // R22: six consecutive bad symbols add one.
    assign symbolInc = rxFrameActive && symbolValid && symbolBad &&
                       badRun == 3'(SYMBOL_RUN_LEN - 1);
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            badRun <= '0;
        end else if (ce) begin
            if (!rxFrameActive || symbolInc) begin
                badRun <= '0;
            end else if (symbolValid) begin
                badRun <= symbolBad ? badRun + 3'd1 : 3'd0;
            end
        end
    end

    // ------------------------------------------------------------
    // Event counters.
    // ------------------------------------------------------------
    logic [CNT_WIDTH-1:0] cntFalse, cntDisc, cntFrame, cntSym;

    // R19: false carrier count.
    sat_clr_counter #(.WIDTH(CNT_WIDTH)) uFalse (
        .refClk(ref_clk), .rstN(rstN), .ce(ce), .incr(falseCarrierEvt),
        .clr(readPulse && regAddr == REG_FALSE_CARRIER), .count(cntFalse)
    );
    // R20: disconnect count.
    sat_clr_counter #(.WIDTH(CNT_WIDTH)) uDisc (
        .refClk(ref_clk), .rstN(rstN), .ce(ce), .incr(disconnectEvt),
        .clr(readPulse && regAddr == REG_DISCONNECT), .count(cntDisc)
    );
    // R21: error frame count.
    sat_clr_counter #(.WIDTH(CNT_WIDTH)) uFrame (
        .refClk(ref_clk), .rstN(rstN), .ce(ce), .incr(errFrameInc),
        .clr(readPulse && regAddr == REG_ERROR_FRAME), .count(cntFrame)
    );
    // R22: symbol error count.
    sat_clr_counter #(.WIDTH(CNT_WIDTH)) uSym (
        .refClk(ref_clk), .rstN(rstN), .ce(ce), .incr(symbolInc),
        .clr(readPulse && regAddr == REG_SYMBOL_ERROR), .count(cntSym)
    );

    // ------------------------------------------------------------
    // Read multiplexer.
    // ------------------------------------------------------------
    // R1 R18: reserved and unmapped indices read zero.
    always_comb begin
        rdValue = 16'h0000;
        case (regAddr)
            REG_STATUS_CTRL: rdValue = {statusCtrlWr, inSync, pd100, pd10, polRev,
                                        6'h00, spd100, fdx};
            REG_SPECIAL_CTRL: rdValue = specialCtrl;
            REG_MGMT_ADDR: rdValue = {11'h000, PHY_ADDRESS};
            REG_FALSE_CARRIER: rdValue = 16'(cntFalse);
            REG_DISCONNECT: rdValue = 16'(cntDisc);
            REG_ERROR_FRAME: rdValue = 16'(cntFrame);
            REG_SYMBOL_ERROR: rdValue = 16'(cntSym);
            default: rdValue = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    chk_reserved_zero: assert property ( // R1
        (regAddr >= REG_RSVD_LO && regAddr <= REG_RSVD_HI) |-> rdValue == 16'h0000)
        else $error("Reserved index returned nonzero data.");
    chk_csd_write: assert property ( // R2
        (ce && writePulse && regAddr == REG_STATUS_CTRL) |=> carrierDisconnectEn == $past(wrShift[13]))
        else $error("Disconnect enable did not take written value.");
    chk_flow_write: assert property ( // R3
        (ce && writePulse && regAddr == REG_STATUS_CTRL) |=> txFlowCtrlEn == $past(wrShift[12]))
        else $error("Flow control enable did not take written value.");
    chk_status_map: assert property ( // R7
        regAddr == REG_STATUS_CTRL |-> rdValue[1:0] == {spd100, fdx} && rdValue[11:8] ==
        {inSync, pd100, pd10, polRev})
        else $error("Status bits misplaced in read data.");
    chk_special_write: assert property ( // R8
        (ce && writePulse && regAddr == REG_SPECIAL_CTRL) |=> specialCtrl == $past(wrShift) ##1
        specialCtrl == $past(specialCtrl) || $past(writePulse))
        else $error("Special control write lost.");
    chk_addr_fixed: assert property ( // R18
        regAddr == REG_MGMT_ADDR |-> rdValue == 16'h0001)
        else $error("Address register not fixed.");
    chk_frame_once: assert property ( // R21
        errSeen |-> !errFrameInc)
        else $error("Error frame counted twice in one frame.");
    chk_symbol_run: assert property ( // R22
        symbolInc |-> $past(badRun) == 3'(SYMBOL_RUN_LEN - 2) || $past(badRun) == badRun)
        else $error("Symbol count outside a six symbol run.");
    chk_read_drive: assert property ( // R23
        (ce && readPulse) ##1 (!mdcFall)[*1] |-> rdShift == $past(rdValue))
        else $error("Read data not captured at address end.");

    cov_read: cover property (readPulse);
    cov_write: cover property (writePulse && regAddr == REG_SPECIAL_CTRL);
    cov_symbol: cover property (symbolInc);
    cov_race: cover property (readPulse && regAddr == REG_DISCONNECT && disconnectEvt);
endmodule
`default_nettype wire

// *** mdio_master.sv ***
/*
 * Station manager model that runs full management frames on the serial port.
 * Assumes the device drives the data pin only while its enable is high.
 */
`default_nettype none
module mdio_master (
    input wire logic refClk,
    input wire logic devOut,
    input wire logic devOe,
    output logic mdc,
    output logic wireLvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mOe = 1'b0;
    logic mOut = 1'b1;
    initial mdc = 1'b0;
    // The pull-up holds the line high whenever nobody drives it.
    assign wireLvl = devOe ? devOut : (mOe ? mOut : 1'b1);
    // Runs one frame; the clock stands low between frames.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regIdx,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [63:0] bits;
        int nDrive;
        bits = {32'hFFFF_FFFF, 2'b01, op, phy, regIdx, 2'b10, wdata};
        nDrive = (op == 2'b01) ? 64 : 46;
        for (int i = 63; i >= 0; i--) begin
            mOe <= (63 - i) < nDrive;
            mOut <= bits[i];
            mdc <= 1'b0;
            repeat (5) @(posedge refClk);
            rdata = {rdata[14:0], wireLvl};
            mdc <= 1'b1;
            repeat (5) @(posedge refClk);
        end
        mdc <= 1'b0;
        mOe <= 1'b0;
        repeat (6) @(posedge refClk);
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench for the vendor management register bank.
 * Assumes the station manager model in mdio_master.sv on the serial port.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import phy_mgmt_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [5:0] st = 6'h00;
    logic [5:0] ev = 6'h00;
    logic mdc, mdioLine, mdioOut, mdioOe, cde, tfc;
    wire [14:0] sp;
    int miscompares = 0;
    int samplesChecked = 0;
    int cycles = 0;
    phy_vendor_mgmt_registers dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .mdc(mdc), .mdioIn(mdioLine),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .deserInSync(st[5]), .powerDown100(st[4]), .powerDown10(st[3]),
        .polarityReversed(st[2]), .speed100(st[1]), .fullDuplex(st[0]), .falseCarrierEvt(ev[0]),
        .disconnectEvt(ev[1]), .rxFrameActive(ev[5]), .rxErrorEvt(ev[2]), .symbolValid(ev[3] | ev[4]),
        .symbolBad(ev[3]), .carrierDisconnectEn(cde), .txFlowCtrlEn(tfc), .scramblerBypass(sp[14]),
        .encoderBypass(sp[13]), .forceHPattern(sp[12]), .force34Pattern(sp[11]), .forceLinkGood(sp[10]),
        .txCarrierSenseDis(sp[9]), .dynPowerDownDis(sp[8]), .anegLoopback(sp[7]), .txDriverTristate(sp[6]),
        .rxFilterBypass(sp[5]), .autoPolarityDis(sp[4]), .squelchTestDis(sp[3]), .extSquelchEn(sp[2]),
        .linkIntegrityDis(sp[1]), .jabberDis(sp[0]));
    mdio_master mgr (.refClk(ref_clk), .devOut(mdioOut), .devOe(mdioOe), .mdc(mdc), .wireLvl(mdioLine));
    // Free-running 200 MHz clock.
    always #2.5 ref_clk = ~ref_clk;
    // Cuts a hang short at cycle 90000, only a few thousand cycles after the expected run of about 83000 cycles.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            results();
        end
    end
    // Shared comparison, register access and event helpers.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [4:0] idx, input logic [15:0] exp, input string what);
        logic [15:0] d;
        mgr.frame(OP_READ, PHY_ADDRESS, idx, 16'h0000, d);
        chk(what, exp, d);
    endtask
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        logic [15:0] ignored;
        mgr.frame(OP_WRITE, PHY_ADDRESS, idx, d, ignored);
    endtask
    task automatic hold(input int b, input int n);
        @(posedge ref_clk);
        ev[b] <= 1'b1;
        repeat (n) @(posedge ref_clk);
        ev[b] <= 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence of register and counter scenarios.
    initial begin
        logic [15:0] pat [3] = '{16'hFFFF, 16'hA5A5, 16'h5A5A};
        logic [4:0] rsv [2] = '{REG_RSVD_LO, REG_RSVD_HI};
        logic [15:0] d;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("special outputs", 16'h0000, {1'b0, sp});
        chk("status ctrl outputs", 16'h0000, {14'h0000, cde, tfc});
        rd(REG_SPECIAL_CTRL, SPECIAL_RESET, "special reset");
        st <= 6'b101110;
        rd(REG_STATUS_CTRL, 16'h0B02, "status levels");
        st <= 6'b010001;
        rd(REG_STATUS_CTRL, 16'h0401, "status levels");
        foreach (pat[i]) begin
            wr(REG_SPECIAL_CTRL, pat[i]);
            chk("special outputs", {1'b0, pat[i][15:11], pat[i][9:0]}, {1'b0, sp});
            rd(REG_SPECIAL_CTRL, pat[i], "special readback");
        end
        wr(REG_STATUS_CTRL, 16'h2FFF);
        chk("status ctrl outputs", 16'h0002, {14'h0000, cde, tfc});
        wr(REG_STATUS_CTRL, 16'h1FFF);
        chk("status ctrl outputs", 16'h0001, {14'h0000, cde, tfc});
        rd(REG_STATUS_CTRL, 16'h1401, "status ctrl readback");
        wr(REG_MGMT_ADDR, 16'hFFFF);
        rd(REG_MGMT_ADDR, {11'h000, PHY_ADDRESS}, "management address");
        foreach (rsv[i]) begin
            wr(rsv[i], 16'hFFFF);
            rd(rsv[i], 16'h0000, "reserved index");
        end
        // A frame for another station address must leave the line released.
        mgr.frame(OP_READ, 5'h02, REG_MGMT_ADDR, 16'h0000, d);
        chk("foreign station line", 16'hFFFF, d);
        ce <= 1'b0;
        hold(0, 4);
        ce <= 1'b1;
        hold(0, 3);
        rd(REG_FALSE_CARRIER, 16'h0003, "false carrier count");
        rd(REG_FALSE_CARRIER, 16'h0000, "false carrier cleared");
        hold(1, 65540);
        rd(REG_DISCONNECT, 16'hFFFF, "disconnect saturated");
        rd(REG_DISCONNECT, 16'h0000, "disconnect cleared");
        // A read inside an event burst must lose no event across its clear.
        fork
            hold(1, 600);
            mgr.frame(OP_READ, PHY_ADDRESS, REG_DISCONNECT, 16'h0000, d);
        join
        chk("disconnect early part", 16'h0001, {15'h0000, d != 16'h0000 && d != 16'd600});
        rd(REG_DISCONNECT, 16'd600 - d, "disconnect split");
        ev[5] <= 1'b1;
        hold(2, 3);
        @(posedge ref_clk);
        ev[5] <= 1'b0;
        @(posedge ref_clk);
        ev[5] <= 1'b1;
        hold(2, 1);
        hold(3, 13);
        hold(4, 1);
        hold(3, 5);
        @(posedge ref_clk);
        ev[5] <= 1'b0;
        rd(REG_ERROR_FRAME, 16'h0002, "error frame count");
        rd(REG_SYMBOL_ERROR, 16'h0002, "symbol error count");
        results();
    end
endmodule
`default_nettype wire
